// ### design/sha_core.sv
// Purpose: Servo drive logic for torque source selection, servo enable and homing.
// Assumes: Inputs are synchronous to i_clk; APB slave answers with no wait state.
// Notes: Motion is requested through o_motion; position follows i_step pulses.
// Operation
// - Torque source value 1 selects analog command; bit 7 inverts its polarity.
// - Control mode 3 puts the drive in torque control from the selected source.
// - Control word bit 0 enables the servo; cleared after reset.
// - In torque control the shaft is not held at a fixed position.
// - Homing offers origin-signal methods and a mechanical stopper method.
// - Method 0 moves to nearest motor zero after origin, then loads preset.
// - Method 2 stops immediately on origin and loads preset.
// - Method 3 reverses until origin clears, then loads preset.
// - Origin comes from a digital input or from the host control bit.
// - Input assignments 100 to 105 may map the home sensor onto an input.
// - Control word bit 13 serves as host origin indication during homing.
// - Stopper homing pushes against the stopper end, then loads preset.
// - Push duration and push torque are host registers.
// - Method codes: 0 motor zero, 2 immediate stop, 3 reverse until clear.
// - Enabling the servo clears the current command register to zero, unless a write to that register lands in the same cycle.
// - Writing 1 to the save register pulses a commit request.
//
// Chosen here: the APB register port.
`default_nettype none
module sha_core #(
  parameter int TICK_CYCLES = sha_pkg::PUSH_UNIT_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire sha_pkg::sha_apb_req_t i_apb,
  input wire logic [sha_pkg::N_DIN-1:0] i_din,
  input wire logic i_motor_zero,
  input wire logic i_step,
  input wire logic i_step_dir,
  input wire logic [15:0] i_adc,
  output sha_pkg::sha_apb_rsp_t o_apb,
  output sha_pkg::sha_motion_t o_motion,
  output logic [31:0] o_pos,
  output logic o_home_done,
  output logic o_homing,
  output logic o_save_pulse
);
  import sha_pkg::*;

  sha_state_t st;
  sha_state_t n;
  logic [7:0] idx;
  logic setup;
  logic wr;
  logic wr_curr;
  logic mapped;
  logic [N_DIN-1:0] home_map;
  logic origin;
  logic org_rise;
  logic load;
  logic enabled;

  always_comb begin
    n = st;
    idx = i_apb.paddr[9:2];
    setup = i_apb.psel && !i_apb.penable;
    wr = i_apb.psel && i_apb.penable && st.apb.pready && i_apb.pwrite;
    mapped = (i_apb.paddr[ADDR_W-1:10] == '0) && (i_apb.paddr[1:0] == 2'h0) &&
             (idx == ID_SAVE || idx == ID_CTRL || idx == ID_MODE || idx == ID_CURR ||
              idx == ID_TSEL || idx == ID_HTYPE || idx == ID_PRESET || idx == ID_THR_TIME ||
              idx == ID_THR_TORQ || idx == ID_STATUS || idx == ID_POS ||
              (idx >= ID_DIN_FIRST && idx <= ID_DIN_LAST));
    wr_curr = wr && mapped && idx == ID_CURR;
    enabled = st.ctrl[CTRL_EN];
    for (int i = 0; i < N_DIN; i++) begin
      home_map[i] = (st.din_func[i] == FUNC_HOME);
    end
    origin = (|(st.sync2 & home_map)) || st.ctrl[CTRL_HARM];
    org_rise = origin && !st.org_prev;
    load = 1'b0;

    n.sync1 = i_din;
    n.sync2 = st.sync1;
    n.org_prev = origin;
    n.en_prev = enabled;
    n.start_prev = st.ctrl[CTRL_HSTART];
    n.save_pulse = 1'b0;
    if (enabled && !st.en_prev) begin
      n.curr = 16'h0000;
    end

    // Bus access: read data and error are prepared in the setup cycle.
    n.apb.pready = setup;
    n.apb.pslverr = setup && !mapped;
    n.apb.prdata = 32'h0000_0000;
    if (setup && mapped) begin
      if (idx >= ID_DIN_FIRST && idx <= ID_DIN_LAST) begin
        n.apb.prdata = {24'h000000, st.din_func[3'(idx - ID_DIN_FIRST)]};
      end else begin
        unique case (idx)
          ID_CTRL: n.apb.prdata = {16'h0000, st.ctrl};
          ID_MODE: n.apb.prdata = {16'h0000, st.mode};
          ID_CURR: n.apb.prdata = {16'h0000, st.curr};
          ID_TSEL: n.apb.prdata = {16'h0000, st.tsel};
          ID_HTYPE: n.apb.prdata = {16'h0000, st.htype};
          ID_PRESET: n.apb.prdata = st.preset;
          ID_THR_TIME: n.apb.prdata = {16'h0000, st.thr_time};
          ID_THR_TORQ: n.apb.prdata = {16'h0000, st.thr_torq};
          ID_STATUS: n.apb.prdata = {18'h00000, st.fsm, 6'h00, st.fsm != ST_IDLE,
                                     st.home_done};
          ID_POS: n.apb.prdata = st.pos;
          default: n.apb.prdata = 32'h0000_0000;
        endcase
      end
    end
    if (wr && mapped) begin
      if (idx >= ID_DIN_FIRST && idx <= ID_DIN_LAST) begin
        n.din_func[3'(idx - ID_DIN_FIRST)] = i_apb.pwdata[7:0];
      end else begin
        unique case (idx)
          ID_SAVE: n.save_pulse = (i_apb.pwdata[15:0] == SAVE_CMD);
          ID_CTRL: n.ctrl = i_apb.pwdata[15:0];
          ID_MODE: n.mode = i_apb.pwdata[15:0];
          ID_CURR: n.curr = i_apb.pwdata[15:0];
          ID_TSEL: n.tsel = i_apb.pwdata[15:0];
          ID_HTYPE: n.htype = i_apb.pwdata[15:0];
          ID_PRESET: n.preset = i_apb.pwdata;
          ID_THR_TIME: n.thr_time = i_apb.pwdata[15:0];
          ID_THR_TORQ: n.thr_torq = i_apb.pwdata[15:0];
          default: n.home_done = st.home_done;
        endcase
      end
    end

    // Homing sequencer.
    unique case (st.fsm)
      ST_IDLE: begin
        n.tick = 32'h0;
        n.ms_cnt = 16'h0;
        if (enabled && st.ctrl[CTRL_HSTART] && !st.start_prev) begin
          n.home_done = 1'b0;
          if (st.htype == HT_STOPPER) begin
            n.fsm = ST_PUSH;
          end else if (st.htype == HT_ZERO || st.htype == HT_STOP ||
                       st.htype == HT_BACK) begin
            n.fsm = ST_SEEK;
          end
        end
      end
      ST_SEEK: begin
        if (org_rise) begin
          if (st.htype == HT_STOP) begin
            load = 1'b1;
          end else if (st.htype == HT_BACK) begin
            n.fsm = ST_BACK;
          end else begin
            n.fsm = ST_ZERO;
          end
        end
      end
      ST_ZERO: begin
        load = i_motor_zero;
      end
      ST_BACK: begin
        load = !origin;
      end
      ST_PUSH: begin
        if (st.ms_cnt >= st.thr_time) begin
          load = 1'b1;
        end else if (st.tick == 32'(TICK_CYCLES - 1)) begin
          n.tick = 32'h0;
          n.ms_cnt = st.ms_cnt + 16'h0001;
        end else begin
          n.tick = st.tick + 32'h1;
        end
      end
      default: n.fsm = ST_IDLE;
    endcase
    if (load) begin
      n.fsm = ST_IDLE;
      n.home_done = 1'b1;
    end
    if (!enabled) begin
      n.fsm = ST_IDLE;
    end

    if (load) begin
      n.pos = st.preset;
    end else if (i_step) begin
      n.pos = i_step_dir ? st.pos + 32'h1 : st.pos - 32'h1;
    end

    // Motion outputs follow the next state so they match st on every cycle except after reset, which clears move_dir while st is in ST_IDLE.
    n.mot.move_en = n.fsm == ST_SEEK || n.fsm == ST_ZERO || n.fsm == ST_BACK;
    n.mot.move_dir = n.fsm != ST_BACK;
    n.mot.torque_mode = n.ctrl[CTRL_EN] && n.mode == MODE_TORQUE;
    n.mot.hold_en = n.ctrl[CTRL_EN] && n.mode != MODE_TORQUE &&
                    !n.mot.move_en && n.fsm != ST_PUSH;
    if (n.fsm == ST_PUSH) begin
      n.mot.torque_cmd = n.thr_torq;
    end else if (n.mot.torque_mode && n.tsel[6:0] == TSEL_ANALOG) begin
      n.mot.torque_cmd = n.tsel[TSEL_INV] ? (~i_adc + 16'h0001) : i_adc;
    end else if (n.mot.torque_mode) begin
      n.mot.torque_cmd = n.curr;
    end else begin
      n.mot.torque_cmd = 16'h0000;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '0;
      st.fsm <= ST_IDLE;
    end else if (i_ce) begin
      st <= n;
    end
  end

  assign o_apb = st.apb;
  assign o_motion = st.mot;
  assign o_pos = st.pos;
  assign o_home_done = st.home_done;
  assign o_homing = st.mot.move_en;
  assign o_save_pulse = st.save_pulse;

  chk_enable_clears_cmd: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && enabled && !st.en_prev && !wr_curr |=> st.curr == 16'h0000)
    else $error("current command not cleared on enable");
  chk_torque_no_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    st.ctrl[CTRL_EN] && st.mode == MODE_TORQUE |-> !o_motion.hold_en && o_motion.torque_mode)
    else $error("position hold active in torque mode");
  chk_stop_preset: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && enabled && st.fsm == ST_SEEK && org_rise && st.htype == HT_STOP
    |=> st.fsm == ST_IDLE && st.pos == $past(st.preset) && o_home_done)
    else $error("immediate stop did not load preset");
  chk_zero_preset: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && enabled && st.fsm == ST_ZERO && i_motor_zero |=> st.pos == $past(st.preset))
    else $error("motor zero did not load preset");
  chk_back_dir: assert property (@(posedge i_clk) disable iff (i_rst)
    st.fsm == ST_BACK |-> o_motion.move_en && !o_motion.move_dir)
    else $error("back-off not moving in reverse");
  chk_back_exit: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && enabled && st.fsm == ST_BACK && !origin |=> st.fsm == ST_IDLE && o_home_done)
    else $error("back-off did not end when origin cleared");
  chk_push_torque: assert property (@(posedge i_clk) disable iff (i_rst)
    st.fsm == ST_PUSH |-> o_motion.torque_cmd == st.thr_torq && !o_motion.move_en)
    else $error("stopper push torque wrong");
  chk_host_origin: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && enabled && st.fsm == ST_SEEK && st.ctrl[CTRL_HARM] && !st.org_prev &&
    st.htype == HT_BACK |=> st.fsm == ST_BACK)
    else $error("host origin bit ignored");
  chk_save_pulse: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && wr && mapped && idx == ID_SAVE && i_apb.pwdata[15:0] == SAVE_CMD
    |=> o_save_pulse ##1 !o_save_pulse)
    else $error("save request not pulsed once");
  chk_sensor_sync: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce [*3] ##0 (home_map[0] && !st.ctrl[CTRL_HARM] && !origin && $stable(home_map))
    |-> st.sync2[0] == $past(i_din[0], 2))
    else $error("home input not taken through two stages");

  // Homing entry, abort and motion direction.
  chk_start_seek: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && enabled && st.fsm == ST_IDLE && st.ctrl[CTRL_HSTART] && !st.start_prev &&
    (st.htype == HT_ZERO || st.htype == HT_STOP || st.htype == HT_BACK) |=> st.fsm == ST_SEEK)
    else $error("homing start did not enter seek");
  chk_start_push: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && enabled && st.fsm == ST_IDLE && st.ctrl[CTRL_HSTART] && !st.start_prev &&
    st.htype == HT_STOPPER |=> st.fsm == ST_PUSH)
    else $error("stopper start did not enter push");
  chk_disable_abort: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && !enabled |=> st.fsm == ST_IDLE)
    else $error("homing kept running with servo off");
  chk_zero_wait: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && enabled && st.fsm == ST_ZERO && !i_motor_zero |=> st.fsm == ST_ZERO)
    else $error("motor zero search ended without zero mark");
  chk_seek_forward: assert property (@(posedge i_clk) disable iff (i_rst)
    st.fsm == ST_SEEK || st.fsm == ST_ZERO |-> o_motion.move_en && o_motion.move_dir && o_homing)
    else $error("origin search not moving forward");
  chk_idle_still: assert property (@(posedge i_clk) disable iff (i_rst)
    st.fsm == ST_IDLE |-> !o_motion.move_en && !o_homing)
    else $error("motion requested while homing idle");
  chk_push_exit: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && enabled && st.fsm == ST_PUSH && st.ms_cnt >= st.thr_time |=>
    st.fsm == ST_IDLE && st.pos == $past(st.preset) && o_home_done)
    else $error("stopper push did not end with preset");

  // Torque command source; the command was built from the input of the previous cycle.
  chk_curr_source: assert property (@(posedge i_clk) disable iff (i_rst)
    st.ctrl[CTRL_EN] && st.mode == MODE_TORQUE && st.fsm != ST_PUSH &&
    st.tsel[6:0] != TSEL_ANALOG |-> o_motion.torque_cmd == st.curr)
    else $error("torque command not taken from current register");
  chk_analog_plain: assert property (@(posedge i_clk) disable iff (i_rst)
    $past(i_ce) && st.ctrl[CTRL_EN] && st.mode == MODE_TORQUE && st.fsm != ST_PUSH &&
    st.tsel[6:0] == TSEL_ANALOG && !st.tsel[TSEL_INV] |->
    o_motion.torque_cmd == $past(i_adc))
    else $error("analog torque command not passed through");
  chk_analog_invert: assert property (@(posedge i_clk) disable iff (i_rst)
    $past(i_ce) && st.ctrl[CTRL_EN] && st.mode == MODE_TORQUE && st.fsm != ST_PUSH &&
    st.tsel[6:0] == TSEL_ANALOG && st.tsel[TSEL_INV] |->
    o_motion.torque_cmd == (~$past(i_adc) + 16'h0001))
    else $error("analog torque command not inverted");

  // Bus answer and clock enable.
  chk_ce_freeze: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_ce |=> $stable(st))
    else $error("state changed while clock enable low");
  chk_apb_error: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && i_apb.psel && !i_apb.penable && !mapped |=>
    o_apb.pready && o_apb.pslverr && o_apb.prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  chk_ready_once: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && o_apb.pready |=> !o_apb.pready)
    else $error("bus ready held longer than one cycle");
endmodule : sha_core
`default_nettype wire

// ### design/sha_pkg.sv
// Purpose: Shared constants and types for the servo homing and analog torque block.
// Assumes: Parameter registers sit at word index = parameter number on an APB bus.
// Notes: Byte address of a register is four times its index.
`default_nettype none
package sha_pkg;
  localparam int CLK_NS = 10;
  localparam int PUSH_UNIT_NS = 1000000;
  localparam int PUSH_UNIT_CYCLES = (PUSH_UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int ADDR_W = 12;
  localparam int N_DIN = 6;
  // Register indices.
  localparam logic [7:0] ID_SAVE = 8'h11;
  localparam logic [7:0] ID_CTRL = 8'h1e;
  localparam logic [7:0] ID_MODE = 8'h1f;
  localparam logic [7:0] ID_CURR = 8'h26;
  localparam logic [7:0] ID_TSEL = 8'h4c;
  localparam logic [7:0] ID_HTYPE = 8'h5a;
  localparam logic [7:0] ID_PRESET = 8'h5b;
  localparam logic [7:0] ID_THR_TIME = 8'h5c;
  localparam logic [7:0] ID_THR_TORQ = 8'h5d;
  localparam logic [7:0] ID_STATUS = 8'h5e;
  localparam logic [7:0] ID_POS = 8'h5f;
  localparam logic [7:0] ID_DIN_FIRST = 8'h64;
  localparam logic [7:0] ID_DIN_LAST = 8'h69;
  // Field positions and codes.
  localparam int CTRL_EN = 0;
  localparam int CTRL_HSTART = 4;
  localparam int CTRL_HARM = 13;
  localparam int TSEL_INV = 7;
  localparam logic [6:0] TSEL_ANALOG = 7'h01;
  localparam logic [15:0] MODE_TORQUE = 16'h0003;
  localparam logic [15:0] HT_ZERO = 16'h0000;
  localparam logic [15:0] HT_STOP = 16'h0002;
  localparam logic [15:0] HT_BACK = 16'h0003;
  localparam logic [15:0] HT_STOPPER = 16'h0004;
  localparam logic [7:0] FUNC_HOME = 8'h01;
  localparam logic [15:0] SAVE_CMD = 16'h0001;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_SEEK = 6'h02,
    ST_ZERO = 6'h04,
    ST_BACK = 6'h08,
    ST_PUSH = 6'h10,
    ST_SPARE = 6'h20
  } sha_fsm_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } sha_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } sha_apb_rsp_t;

  typedef struct packed {
    logic move_en;
    logic move_dir;
    logic hold_en;
    logic torque_mode;
    logic [15:0] torque_cmd;
  } sha_motion_t;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] mode;
    logic [15:0] curr;
    logic [15:0] tsel;
    logic [15:0] htype;
    logic [31:0] preset;
    logic [15:0] thr_time;
    logic [15:0] thr_torq;
    logic [N_DIN-1:0][7:0] din_func;
    logic [N_DIN-1:0] sync1;
    logic [N_DIN-1:0] sync2;
    logic org_prev;
    logic en_prev;
    logic start_prev;
    sha_fsm_t fsm;
    logic [31:0] tick;
    logic [15:0] ms_cnt;
    logic [31:0] pos;
    logic home_done;
    logic save_pulse;
    sha_apb_rsp_t apb;
    sha_motion_t mot;
  } sha_state_t;
endpackage : sha_pkg
`default_nettype wire

// ### sim/sha_plant.sv
// Purpose: Motor and home sensor model standing at the far side of the block.
// Assumes: One position count every other cycle while motion is requested.
// Notes: The home sensor is high over a band of counts on each side of zero.
`default_nettype none
module sha_plant (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_rezero,
  input wire sha_pkg::sha_motion_t i_motion,
  input wire logic [2:0] i_sel,
  output logic o_step,
  output logic o_step_dir,
  output logic o_motor_zero,
  output logic [sha_pkg::N_DIN-1:0] o_din
);
  timeunit 1ns;
  timeprecision 1ps;
  import sha_pkg::*;
  logic signed [31:0] p;
  logic ph;
  logic sensor;
  always_ff @(posedge i_clk) begin
    if (i_rst || i_rezero) begin
      p <= 0;
      ph <= 1'b0;
    end else begin
      ph <= ~ph;
      if (o_step) p <= o_step_dir ? p + 1 : p - 1;
    end
  end
  assign o_step = i_motion.move_en & ph;
  assign o_step_dir = i_motion.move_dir;
  assign sensor = (p >= 20 && p < 36) || (p <= -20 && p > -36);
  assign o_motor_zero = (p[2:0] == 3'h0);
  assign o_din = N_DIN'(sensor) << i_sel;
endmodule // sha_plant
`default_nettype wire

// ### sim/tb_servo_homing_and_analog_torque.sv
// Purpose: Self-checking bench for the homing and torque block.
// Assumes: TICK_CYCLES is 4 so a push unit lasts four cycles.
// Notes: Registers are reached through an APB master task.
`default_nettype none
module tb_servo_homing_and_analog_torque;
  timeunit 1ns;
  timeprecision 1ps;
  import sha_pkg::*;
  logic i_clk, i_rst, rez, step, sdir, mz, ce;
  logic [2:0] sel;
  logic [N_DIN-1:0] din;
  logic [15:0] adc;
  sha_apb_req_t req;
  sha_apb_rsp_t rsp;
  sha_motion_t mot;
  logic [31:0] pos, rd, pre;
  logic done, homing, save, err;
  int fail_count = 0, n_checks = 0, nsave = 0, seed = 32'hc26d02aa, n;
  logic [7:0] ids[9] = '{ID_CTRL, ID_MODE, ID_CURR, ID_TSEL, ID_HTYPE, ID_PRESET,
    ID_THR_TIME, ID_THR_TORQ, ID_POS};
  logic [15:0] ht[3] = '{HT_ZERO, HT_STOP, HT_BACK};
  sha_core #(.TICK_CYCLES(4)) sha_core_inst (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce),
    .i_apb(req), .i_din(din), .i_motor_zero(mz), .i_step(step), .i_step_dir(sdir),
    .i_adc(adc), .o_apb(rsp), .o_motion(mot), .o_pos(pos), .o_home_done(done),
    .o_homing(homing), .o_save_pulse(save));
  sha_plant sha_plant_inst (.i_clk(i_clk), .i_rst(i_rst), .i_rezero(rez), .i_motion(mot),
    .i_sel(sel), .o_step(step), .o_step_dir(sdir), .o_motor_zero(mz), .o_din(din));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) if (save === 1'b1) nsave++;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] neg16(input logic [15:0] v);
    return ~v + 16'h0001;
  endfunction
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge i_clk);
    req <= '{1'b1, 1'b0, w, {2'b00, idx, 2'b00}, wd};
    @(posedge i_clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    rd = rsp.prdata;
    err = rsp.pslverr;
    if (rsp.pready !== 1'b1) fail_count++;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    check(rd, exp);
  endtask
  task automatic settle();
    repeat (2) @(posedge i_clk);
  endtask
  task automatic home(input logic [15:0] t, input logic host);
    @(posedge i_clk) rez <= 1'b1;
    @(posedge i_clk) rez <= 1'b0;
    pre = $random(seed);
    apb(1'b1, ID_PRESET, pre);
    apb(1'b1, ID_HTYPE, {16'h0, t});
    apb(1'b1, ID_CTRL, 32'h1);
    apb(1'b1, ID_CTRL, 32'h11);
    settle();
    if (host) begin
      repeat (20) @(posedge i_clk);
      apb(1'b1, ID_CTRL, 32'h2011);
    end
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge i_clk);
      n++;
    end
    check(done, 1'b1);
    check(pos, pre);
    check(homing, 1'b0);
    apb(1'b1, ID_CTRL, 32'h1);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #600000;
    fail_count++;
    final_report();
  end
  initial begin
    i_rst = 1'b1;
    rez = 1'b0;
    ce = 1'b1;
    req = '0;
    adc = $random(seed);
    sel = 3'h2;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    check(mot, '0);
    foreach (ids[i]) rdchk(ids[i], 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check(err, 1'b1);
    apb(1'b1, ID_CURR, {16'h0, 16'h1234});
    apb(1'b1, ID_MODE, {16'h0, MODE_TORQUE});
    apb(1'b1, ID_CTRL, 32'h1);
    rdchk(ID_CURR, 32'h0);
    apb(1'b1, ID_CURR, 32'h0000_0321);
    settle();
    check(mot.torque_cmd, 16'h0321);
    check({mot.torque_mode, mot.hold_en}, 2'b10);
    apb(1'b1, ID_TSEL, 32'h1);
    settle();
    check(mot.torque_cmd, adc);
    apb(1'b1, ID_TSEL, 32'h81);
    settle();
    check(mot.torque_cmd, neg16(adc));
    apb(1'b1, ID_MODE, 32'h0);
    settle();
    check({mot.hold_en, mot.torque_cmd}, {1'b1, 16'h0});
    apb(1'b1, ID_SAVE, {16'h0, SAVE_CMD});
    settle();
    check(nsave, 1);
    home(HT_STOP, 1'b1);
    apb(1'b1, ID_DIN_FIRST + 8'h2, {24'h0, FUNC_HOME});
    foreach (ht[i]) home(ht[i], 1'b0);
    apb(1'b1, ID_THR_TIME, 32'h3);
    apb(1'b1, ID_THR_TORQ, 32'h0000_0777);
    apb(1'b1, ID_HTYPE, {16'h0, HT_STOPPER});
    apb(1'b1, ID_CTRL, 32'h11);
    settle();
    check({done, mot.torque_cmd}, {1'b0, 16'h0777});
    n = 0;
    while (done !== 1'b1 && n < 100) begin
      @(posedge i_clk);
      n++;
    end
    check(n, 3 * 4 + 1);
    check(pos, pre);
    apb(1'b1, ID_MODE, {16'h0, MODE_TORQUE});
    settle();
    check(mot.torque_cmd, neg16(adc));
    pre = {16'h0, neg16(adc)};
    ce <= 1'b0;
    adc <= $random(seed);
    repeat (3) @(posedge i_clk);
    check(mot.torque_cmd, pre);
    ce <= 1'b1;
    settle();
    check(mot.torque_cmd, neg16(adc));
    final_report();
  end
endmodule // tb_servo_homing_and_analog_torque
`default_nettype wire
